// ==== hdl/ppc_consts.svh ====
// Purpose: register indices, reset values and widths of the port pin control block
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef PPC_CONSTS_SVH
`define PPC_CONSTS_SVH

// register indices
`define PPC_IDX_S_OD      8'h0e
`define PPC_IDX_M_DATA    8'h10
`define PPC_IDX_M_PIN     8'h11
`define PPC_IDX_M_DIR     8'h12
`define PPC_IDX_M_DRIVE   8'h13
`define PPC_IDX_M_PULLEN  8'h14
`define PPC_IDX_M_PULLPOL 8'h15

// port widths
`define PPC_S_PINS        4
`define PPC_M_PINS        6

// spi pins on port m, receive and transmit pins of can and async serial
`define PPC_M_SPI_LO      2
`define PPC_M_RX_PIN      0
`define PPC_M_TX_PIN      1

// reset values
`define PPC_RST_S_OD      4'h0
`define PPC_RST_M_DATA    6'h00
`define PPC_RST_M_DIR     6'h00
`define PPC_RST_M_DRIVE   6'h00
`define PPC_RST_M_PULLEN  6'h3f
`define PPC_RST_M_PULLPOL 6'h00

`endif

// ==== hdl/ppc_pkg.sv ====
// Purpose: types shared by the port pin control block
// Assumes: nothing
// Notes:   pad control bundles travel as packed structs
package ppc_pkg;

  // one port's pad controls, one bit per pin
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe_n;
    logic [5:0] reduced;
    logic [5:0] pull_up;
    logic [5:0] pull_down;
  } ppc_pads_m_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe_n;
  } ppc_pads_s_t;

  typedef enum logic [0:0] {
    PPC_IDLE   = 1'b0,
    PPC_ACCESS = 1'b1
  } ppc_bus_state_t;

endpackage : ppc_pkg

// ==== hdl/ppc_pin_cell.sv ====
// Purpose: pad control of one bidirectional pin
// Assumes: inputs are the effective settings for the pin
// Notes:   purely combinational; the caller registers the results
`timescale 1ns/100ps
module ppc_pin_cell (
  // effective configuration
  input  wire logic dir_out,
  input  wire logic data,
  input  wire logic open_drain,
  input  wire logic reduce,
  input  wire logic pull_en,
  input  wire logic pull_pol,
  // pad controls
  output logic      pad_out,
  output logic      pad_oe_n,
  output logic      pad_reduced,
  output logic      pad_pull_up,
  output logic      pad_pull_down
);

  logic od_active;
  logic pull_ok;

  always_comb begin
    od_active     = dir_out & open_drain;                       // [RULE2]
    // open drain drives only a low; a one is left floating
    pad_out       = od_active ? 1'b0 : data;                    // [RULE1]
    pad_oe_n      = ~(dir_out & (~od_active | ~data));          // [RULE1]
    pad_reduced   = dir_out & reduce;                           // [RULE11]
    // pull-ups act on inputs and open-drain outputs only; pull-downs act on inputs only
    pull_ok       = pull_en & (~dir_out | od_active);           // [RULE12]
    pad_pull_up   = pull_ok & ~pull_pol;                        // [RULE14]
    pad_pull_down = pull_ok & pull_pol & ~dir_out;              // [RULE14]
  end

endmodule : ppc_pin_cell

// ==== hdl/ppc_top.sv ====
// Purpose: APB register file and pad control for port S open drain and port M
// Assumes: pad inputs and peripheral controls are synchronous to pclk
// Notes:   zero wait-state APB slave; unmapped addresses answer with pslverr
//
// How it works
// [RULE1] port S open drain: drive low only
// [RULE2] open drain ignored on input pins
// [RULE3] data read: latch if output, else pin
// [RULE4] spi status configures port M pins 5..2
// [RULE5] pin state reads pads, writes ignored
// [RULE6] direction bit 0 input, 1 output
// [RULE7] enabled spi or can sets pin direction
// [RULE8] transmit forces output, receive forces input
// [RULE9] channel disabled: direction register controls again
// [RULE10] reads follow direction change within two cycles
// [RULE11] drive bit reduces strength, ignored for inputs
// [RULE12] pull enable only for inputs, open drain
// [RULE13] reset: port M pull-ups enabled
// [RULE14] polarity 0 pull-up, 1 pull-down inputs only
// [RULE15] unimplemented upper bits read zero
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "ppc_consts.svh"
module ppc_top
  import ppc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // port s: data and direction come from the rest of port s
  input  wire logic [3:0]        ps_data,
  input  wire logic [3:0]        ps_dir,
  output logic      [3:0]        ps_pad_out,
  output logic      [3:0]        ps_pad_oe_n,
  // port m pads
  input  wire logic [5:0]        pm_pad_in,
  input  wire logic [5:0]        pm_open_drain,
  output logic      [5:0]        pm_pad_out,
  output logic      [5:0]        pm_pad_oe_n,
  output logic      [5:0]        pm_pad_reduced,
  output logic      [5:0]        pm_pad_pull_up,
  output logic      [5:0]        pm_pad_pull_down,
  // spi controls of port_m_spi_pins
  input  wire logic              spi_enable,
  input  wire logic [3:0]        spi_dir,
  input  wire logic [3:0]        spi_data,
  // can_controller and async_serial_unit channels
  input  wire logic              can_enable,
  input  wire logic              can_tx_data,
  input  wire logic              serial_tx_enable,
  input  wire logic              serial_rx_enable,
  input  wire logic              serial_tx_data
);

  // index decode of a byte address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[9:2] == idx) && (a[ADDR_W-1:10] == '0) && (a[1:0] == 2'b00);
  endfunction : hit

  // zero-extend a port value into a bus word
  function automatic logic [31:0] word6(input logic [5:0] v);
    word6 = {26'h0, v};                                         // [RULE15]
  endfunction : word6

  // ---------------- registers ----------------
  logic [3:0]     s_od_q,      s_od_d;
  logic [5:0]     m_data_q,    m_data_d;
  logic [5:0]     m_dir_q,     m_dir_d;
  logic [5:0]     m_drive_q,   m_drive_d;
  logic [5:0]     m_pullen_q,  m_pullen_d;
  logic [5:0]     m_pullpol_q, m_pullpol_d;
  logic [5:0]     m_pin_q;
  ppc_bus_state_t st_q,        st_d;
  logic [31:0]    rdata_q,     rdata_d;
  logic           ready_q,     ready_d;
  logic           err_q,       err_d;

  logic setup;
  logic wr_en;
  logic mapped;

  always_comb begin
    setup  = psel & ~penable;
    mapped = hit(paddr, `PPC_IDX_S_OD)     | hit(paddr, `PPC_IDX_M_DATA)   |
             hit(paddr, `PPC_IDX_M_PIN)    | hit(paddr, `PPC_IDX_M_DIR)    |
             hit(paddr, `PPC_IDX_M_DRIVE)  | hit(paddr, `PPC_IDX_M_PULLEN) |
             hit(paddr, `PPC_IDX_M_PULLPOL);
    // a write lands at the access edge where pready is sampled high
    wr_en  = psel & penable & ready_q & pwrite & pstrb[0] & ~err_q;
  end

  // bus handshake: pready is raised for the first access cycle
  always_comb begin
    st_d    = st_q;
    ready_d = 1'b0;
    err_d   = 1'b0;
    case (st_q)
      PPC_IDLE: begin
        if (setup) begin
          st_d    = PPC_ACCESS;
          ready_d = 1'b1;
          err_d   = ~mapped;
        end
      end
      PPC_ACCESS: begin
        st_d = PPC_IDLE;
      end
      default: st_d = PPC_IDLE;
    endcase
  end

  // register writes; upper bits are never stored
  always_comb begin
    s_od_d      = s_od_q;
    m_data_d    = m_data_q;
    m_dir_d     = m_dir_q;
    m_drive_d   = m_drive_q;
    m_pullen_d  = m_pullen_q;
    m_pullpol_d = m_pullpol_q;
    if (wr_en) begin
      if (hit(paddr, `PPC_IDX_S_OD))      s_od_d      = pwdata[3:0];    // [RULE15]
      if (hit(paddr, `PPC_IDX_M_DATA))    m_data_d    = pwdata[5:0];
      if (hit(paddr, `PPC_IDX_M_DIR))     m_dir_d     = pwdata[5:0];    // [RULE6]
      if (hit(paddr, `PPC_IDX_M_DRIVE))   m_drive_d   = pwdata[5:0];
      if (hit(paddr, `PPC_IDX_M_PULLEN))  m_pullen_d  = pwdata[5:0];
      if (hit(paddr, `PPC_IDX_M_PULLPOL)) m_pullpol_d = pwdata[5:0];
      // the pin-state index has no write path
    end
  end

  // read data, captured in the setup cycle
  always_comb begin
    rdata_d = 32'h00000000;
    if (setup & ~pwrite) begin
      if (hit(paddr, `PPC_IDX_S_OD))
        rdata_d = {28'h0000000, s_od_q};                        // [RULE15]
      if (hit(paddr, `PPC_IDX_M_DATA))
        rdata_d = word6((m_dir_q & m_data_q) | (~m_dir_q & m_pin_q)); // [RULE3] [RULE10]
      if (hit(paddr, `PPC_IDX_M_PIN))
        rdata_d = word6(m_pin_q);                               // [RULE5]
      if (hit(paddr, `PPC_IDX_M_DIR))     rdata_d = word6(m_dir_q);
      if (hit(paddr, `PPC_IDX_M_DRIVE))   rdata_d = word6(m_drive_q);
      if (hit(paddr, `PPC_IDX_M_PULLEN))  rdata_d = word6(m_pullen_q);
      if (hit(paddr, `PPC_IDX_M_PULLPOL)) rdata_d = word6(m_pullpol_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= PPC_IDLE;
      ready_q     <= 1'b0;
      err_q       <= 1'b0;
      rdata_q     <= 32'h00000000;
      s_od_q      <= `PPC_RST_S_OD;
      m_data_q    <= `PPC_RST_M_DATA;
      m_dir_q     <= `PPC_RST_M_DIR;
      m_drive_q   <= `PPC_RST_M_DRIVE;
      m_pullen_q  <= `PPC_RST_M_PULLEN;                         // [RULE13]
      m_pullpol_q <= `PPC_RST_M_PULLPOL;                        // [RULE13]
      m_pin_q     <= 6'h00;
    end else begin
      st_q        <= st_d;
      ready_q     <= ready_d;
      err_q       <= err_d;
      rdata_q     <= rdata_d;
      s_od_q      <= s_od_d;
      m_data_q    <= m_data_d;
      m_dir_q     <= m_dir_d;
      m_drive_q   <= m_drive_d;
      m_pullen_q  <= m_pullen_d;
      m_pullpol_q <= m_pullpol_d;
      m_pin_q     <= pm_pad_in;                                 // [RULE5]
    end
  end

  always_comb begin
    prdata  = rdata_q;
    pready  = ready_q;
    pslverr = err_q;
  end

  // ---------------- effective port m configuration ----------------
  logic [5:0] m_dir_eff;
  logic [5:0] m_out_eff;
  logic       tx_force;
  logic       rx_force;

  always_comb begin
    m_dir_eff = m_dir_q;                                        // [RULE6] [RULE9]
    m_out_eff = m_data_q;
    tx_force  = can_enable | serial_tx_enable;
    rx_force  = can_enable | serial_rx_enable;
    if (spi_enable) begin
      m_dir_eff[5:`PPC_M_SPI_LO] = spi_dir;                     // [RULE4] [RULE7]
      m_out_eff[5:`PPC_M_SPI_LO] = spi_data;                    // [RULE4]
    end
    if (tx_force) begin
      m_dir_eff[`PPC_M_TX_PIN] = 1'b1;                          // [RULE8] [RULE7]
      m_out_eff[`PPC_M_TX_PIN] = can_enable ? can_tx_data : serial_tx_data;
    end
    if (rx_force) begin
      m_dir_eff[`PPC_M_RX_PIN] = 1'b0;                          // [RULE8] [RULE7]
    end
  end

  // ---------------- pad cells ----------------
  ppc_pads_m_t pm_d, pm_q;
  ppc_pads_s_t ps_d, ps_q;

  for (genvar i = 0; i < `PPC_M_PINS; i++) begin : g_pm
    ppc_pin_cell u_cell (
      .dir_out       (m_dir_eff[i]),
      .data          (m_out_eff[i]),
      .open_drain    (pm_open_drain[i]),
      .reduce        (m_drive_q[i]),                            // [RULE11]
      .pull_en       (m_pullen_q[i]),                           // [RULE12]
      .pull_pol      (m_pullpol_q[i]),                          // [RULE14]
      .pad_out       (pm_d.out[i]),
      .pad_oe_n      (pm_d.oe_n[i]),
      .pad_reduced   (pm_d.reduced[i]),
      .pad_pull_up   (pm_d.pull_up[i]),
      .pad_pull_down (pm_d.pull_down[i])
    );
  end

  for (genvar i = 0; i < `PPC_S_PINS; i++) begin : g_ps
    ppc_pin_cell u_cell (
      .dir_out       (ps_dir[i]),
      .data          (ps_data[i]),
      .open_drain    (s_od_q[i]),                               // [RULE1] [RULE2]
      .reduce        (1'b0),
      .pull_en       (1'b0),
      .pull_pol      (1'b0),
      .pad_out       (ps_d.out[i]),
      .pad_oe_n      (ps_d.oe_n[i]),
      .pad_reduced   (),
      .pad_pull_up   (),
      .pad_pull_down ()
    );
  end

  // pads are registered; reset leaves all pins undriven with port m pulled up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_q <= '{out: 6'h00, oe_n: 6'h3f, reduced: 6'h00,
                pull_up: 6'h3f, pull_down: 6'h00};              // [RULE13]
      ps_q <= '{out: 4'h0, oe_n: 4'hf};
    end else begin
      pm_q <= pm_d;
      ps_q <= ps_d;
    end
  end

  always_comb begin
    pm_pad_out       = pm_q.out;
    pm_pad_oe_n      = pm_q.oe_n;
    pm_pad_reduced   = pm_q.reduced;
    pm_pad_pull_up   = pm_q.pull_up;
    pm_pad_pull_down = pm_q.pull_down;
    ps_pad_out       = ps_q.out;
    ps_pad_oe_n      = ps_q.oe_n;
  end

endmodule : ppc_top

// ==== tb/ppc_pin_model.sv ====
// Purpose: port m pins as seen from outside, with pull devices
// Assumes: a released pin with no pull floats
// Notes:   a floating pin shows a pattern that changes every cycle
`timescale 1ns/100ps
module ppc_pin_model (
  // clock for the float pattern
  input  wire logic       clk,
  // pad controls of the block
  input  wire logic [5:0] out,
  input  wire logic [5:0] oe_n,
  input  wire logic [5:0] pu,
  input  wire logic [5:0] pd,
  // far-side drivers
  input  wire logic [5:0] ext,
  input  wire logic [5:0] ext_oe,
  output logic      [5:0] pin
);
  logic [5:0] flt_q = 6'h15;
  always @(posedge clk) flt_q <= ~flt_q;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin[i] = !oe_n[i] ? out[i] : ext_oe[i] ? ext[i] :
               pu[i] ? 1'b1 : pd[i] ? 1'b0 : flt_q[i];
    end
  end
endmodule : ppc_pin_model

// ==== tb/ppc_top_chk.sv ====
// Purpose: port timing checks of the pin control block
// Assumes: pads follow their causes one cycle later
// Notes:   bound to ppc_top
`timescale 1ns/100ps
`include "ppc_consts.svh"
module ppc_top_chk (
  // bus
  input wire logic       pclk, presetn, psel, penable, pready,
  // port s and spi
  input wire logic [3:0] ps_data, ps_dir, ps_pad_out, ps_pad_oe_n, spi_dir, spi_data,
  // port m
  input wire logic [5:0] pm_open_drain, pm_pad_out, pm_pad_oe_n, pm_pad_pull_up,
  input wire logic [5:0] pm_pad_pull_down,
  // peripherals
  input wire logic       spi_enable, can_enable, can_tx_data,
  input wire logic       serial_tx_enable, serial_rx_enable, serial_tx_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready missing");
  property p_s_in; (ps_pad_oe_n & ~$past(ps_dir)) == ~$past(ps_dir); endproperty
  a_s_in: assert property (p_s_in) else $error("port s input driven");
  property p_s_out; ((ps_pad_out ^ $past(ps_data)) & ~ps_pad_oe_n) == 0; endproperty
  a_s_out: assert property (p_s_out) else $error("port s drives wrong level");
  property p_can; can_enable |=> pm_pad_oe_n[0] &&
    ($past(pm_open_drain[1]) || !pm_pad_oe_n[1] && pm_pad_out[1] == $past(can_tx_data));
  endproperty
  a_can: assert property (p_can) else $error("can pins wrong");
  property p_tx; serial_tx_enable && !can_enable && !pm_open_drain[1] |=>
    !pm_pad_oe_n[1] && pm_pad_out[1] == $past(serial_tx_data); endproperty
  a_tx: assert property (p_tx) else $error("transmit pin not output");
  property p_rx; serial_rx_enable |=> pm_pad_oe_n[0]; endproperty
  a_rx: assert property (p_rx) else $error("receive pin driven");
  property p_spi; spi_enable && pm_open_drain[5:2] == 0 |=> pm_pad_oe_n[5:2] ==
    ~$past(spi_dir) && ((pm_pad_out[5:2] ^ $past(spi_data)) & $past(spi_dir)) == 0;
  endproperty
  a_spi: assert property (p_spi) else $error("spi pins wrong");
  property p_pd; (pm_pad_pull_down & (~pm_pad_oe_n | pm_pad_pull_up)) == 0; endproperty
  a_pd: assert property (p_pd) else $error("pull-down misused");
  property p_pu; (pm_pad_pull_up & ~pm_pad_oe_n & ~$past(pm_open_drain)) == 0; endproperty
  a_pu: assert property (p_pu) else $error("pull-up on push-pull");
  property p_rst; $rose(presetn) |-> pm_pad_pull_up == `PPC_RST_M_PULLEN; endproperty
  a_rst: assert property (p_rst) else $error("reset pull-ups off");
endmodule : ppc_top_chk
bind ppc_top ppc_top_chk chk_u (.*);

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench of the pin control block
// Assumes: zero wait-state slave, pads one cycle after cause
// Notes:   model registers kept in an associative array
`timescale 1ns/100ps
`include "ppc_consts.svh"
module tb_top;
  import ppc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w, seed = 32'h48;
  logic [3:0] pstrb, ps_data, ps_dir, ps_pad_out, ps_pad_oe_n, spi_dir, spi_data, so;
  logic [5:0] pm_pad_in, pm_open_drain, pm_pad_out, pm_pad_oe_n, pm_pad_reduced;
  logic [5:0] pm_pad_pull_up, pm_pad_pull_down, ext, ext_oe, dr, dt, pe, po, oe, pin;
  logic spi_enable, can_enable, can_tx_data;
  logic serial_tx_enable, serial_rx_enable, serial_tx_data;
  int num_errors, comparisons;
  logic [31:0] mdl[int];
  ppc_top dut_u (.*);
  ppc_pin_model pins_u (.clk(pclk), .out(pm_pad_out), .oe_n(pm_pad_oe_n),
    .pu(pm_pad_pull_up), .pd(pm_pad_pull_down), .ext(ext), .ext_oe(ext_oe), .pin(pm_pad_in));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wt, input logic [7:0] idx, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, wt, 2'b00, idx, 2'b00, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // answer taken at the edge where pready is sampled high
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (n >= 50) chk(0, 1);
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
    apb(1, idx, d, s);
    if (s[0] && mdl.exists(idx)) mdl[idx] = d & (idx == `PPC_IDX_S_OD ? 32'hf : 32'h3f);
  endtask : wr
  // reads every register and the pin state against the model
  task automatic chk_regs();
    foreach (mdl[k]) begin
      apb(0, k[7:0], 0, 4'hf);
      chk(rd, k == `PPC_IDX_M_DATA ? {26'h0, (dr & dt) | (~dr & pin)} : mdl[k]);
      chk({31'h0, err}, 32'h0);
    end
    apb(0, `PPC_IDX_M_PIN, 0, 4'hf);
    chk(rd, {26'h0, pin});
  endtask : chk_regs
  task automatic report_and_stop();
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, ext, ext_oe, presetn} = '0;
    {spi_enable, can_enable, can_tx_data, serial_tx_enable, serial_rx_enable,
     serial_tx_data, spi_dir, spi_data, ps_data, ps_dir, pm_open_drain} = '0;
    mdl = '{`PPC_IDX_S_OD:`PPC_RST_S_OD, `PPC_IDX_M_DATA:`PPC_RST_M_DATA,
            `PPC_IDX_M_DIR:`PPC_RST_M_DIR, `PPC_IDX_M_DRIVE:`PPC_RST_M_DRIVE,
            `PPC_IDX_M_PULLEN:`PPC_RST_M_PULLEN, `PPC_IDX_M_PULLPOL:`PPC_RST_M_PULLPOL};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // out of reset every port m pin is an input pulled up
    {dr, dt, pin} = {6'h00, 6'h00, 6'h3f};
    chk_regs();
    wr(8'h16, 32'hffffffff, 4'hf);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    repeat (40) begin
      w = rnd();
      wr(`PPC_IDX_M_DIR, w, 4'hf);
      wr(`PPC_IDX_M_DATA, rnd(), 4'hf);
      // strobe of byte 0 low: must not disturb the value just stored
      wr(`PPC_IDX_M_DATA, rnd(), 4'he);
      wr(`PPC_IDX_M_DRIVE, rnd(), 4'hf);
      wr(`PPC_IDX_M_PULLEN, rnd() | w, 4'hf);
      wr(`PPC_IDX_M_PULLPOL, rnd() & ~w, 4'hf);
      wr(`PPC_IDX_S_OD, rnd(), 4'hf);
      wr(`PPC_IDX_M_PIN, rnd(), 4'hf);
      {dr, dt, pe, po} = {mdl[`PPC_IDX_M_DIR][5:0], mdl[`PPC_IDX_M_DATA][5:0],
                          mdl[`PPC_IDX_M_PULLEN][5:0], mdl[`PPC_IDX_M_PULLPOL][5:0]};
      w = rnd();
      // often leave the spi pins push-pull so the spi check gets exercised
      if (w[28]) w[5:2] = 4'h0;
      {spi_enable, can_enable, can_tx_data, serial_tx_enable, serial_rx_enable,
       serial_tx_data, spi_dir, spi_data, ps_data, ps_dir, pm_open_drain} <= w[27:0];
      ext <= w[31:26];
      ext_oe <= ~dr & (~pe | 6'(rnd()));
      repeat (4) @(posedge pclk);
      {spi_enable, can_enable, serial_tx_enable, serial_rx_enable} <= '0;
      repeat (3) @(posedge pclk);
      oe = ~dr | (pm_open_drain & dt);
      so = ~ps_dir | (mdl[`PPC_IDX_S_OD][3:0] & ps_data);
      pin = (dr & dt) | (~dr & ext_oe & ext) | (~dr & ~ext_oe & ~po);
      chk({8'h0, pm_pad_oe_n, pm_pad_pull_up, pm_pad_pull_down, pm_pad_reduced}, {8'h0, oe,
          pe & ~po & (~dr | oe | pm_open_drain), pe & po & ~dr,
          mdl[`PPC_IDX_M_DRIVE][5:0] & dr});
      chk({18'h0, pm_pad_out & ~oe, ps_pad_oe_n, ps_pad_out & ~so},
          {18'h0, dt & ~oe, so, ps_data & ~so});
      chk_regs();
    end
    report_and_stop();
  end
endmodule : tb_top
